// >>> hw/smac_add16.sv
// One 16-bit adder slice with carry in and carry out
`default_nettype none
module smac_add16 (
    smac_slice_if.slice s
);
    logic [smac_pkg::HALF_W:0] full;
    always_comb begin
        full = {1'b0, s.a} + {1'b0, s.b} +
               {{smac_pkg::HALF_W{1'b0}}, s.cin};
    end
    assign s.sum = full[smac_pkg::HALF_W-1:0];
    assign s.cout = full[smac_pkg::HALF_W];
endmodule
`default_nettype wire

// >>> hw/smac_pkg.sv
// Constants for the signed multiply-accumulate unit
`default_nettype none
package smac_pkg;
    // Widths
    localparam int OP_W = 8;
    localparam int PROD_W = 16;
    localparam int HALF_W = 16;
    localparam int ACC_W = 32;
    localparam int ADDR_W = 8;
    // Register addresses in the unit's register space
    localparam logic [7:0] ADDR_OPERAND_X_PLAIN = 8'h00;
    localparam logic [7:0] ADDR_OPERAND_Y_PLAIN = 8'h01;
    localparam logic [7:0] ADDR_OPERAND_X_ACCUM = 8'h02;
    localparam logic [7:0] ADDR_OPERAND_Y_ACCUM = 8'h03;
    localparam logic [7:0] ADDR_PRODUCT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_PRODUCT_LOW = 8'h05;
    localparam logic [7:0] ADDR_ACCUM_BYTE3 = 8'h06;
    localparam logic [7:0] ADDR_ACCUM_BYTE2 = 8'h07;
    localparam logic [7:0] ADDR_ACCUM_BYTE1 = 8'h08;
    localparam logic [7:0] ADDR_ACCUM_BYTE0 = 8'h09;
    localparam logic [7:0] ADDR_ACCUM_CLEAR_A = 8'h0a;
    localparam logic [7:0] ADDR_ACCUM_CLEAR_B = 8'h0b;
    // Reset values and the all-ones sign-extension half
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [15:0] ONES_HALF = 16'hffff;
    localparam logic [15:0] RST_PROD = 16'h0000;
    localparam logic RST_BIT = 1'b0;
endpackage
`default_nettype wire

// >>> hw/smac_slice_if.sv
// Carrier between the accumulator and one 16-bit adder slice
`default_nettype none
interface smac_slice_if;
    logic [smac_pkg::HALF_W-1:0] a;
    logic [smac_pkg::HALF_W-1:0] b;
    logic cin;
    logic [smac_pkg::HALF_W-1:0] sum;
    logic cout;
    modport user (output a, output b, output cin, input sum, input cout);
    modport slice (input a, input b, input cin, output sum, output cout);
endinterface
`default_nettype wire

// >>> hw/smac_unit.sv
// Signed multiply and multiply-accumulate unit on the CPU data bus
//
// Summary of operation
// - Plain operand write updates product, not accumulator
// - Accumulate operand write adds product into accumulator
// - Both X registers load the one shared X
// - Both Y registers load the one shared Y
// - Any write to either clear zeroes accumulator
// - Operands are 8-bit signed two's complement
// - Product is 16-bit signed, high and low byte
// - Accumulator is 32-bit signed, four bytes
// - Upper accumulator bytes valid one instruction later
// - Plain multiply has no spacing constraint
// - Unit sits in CPU register space
`default_nettype none
module smac_unit (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Internal data bus
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    // Read answer
    output logic [7:0] o_rdata,
    output logic o_rvalid
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    logic wr_xp;
    logic wr_yp;
    logic wr_xa;
    logic wr_ya;
    logic mac_w;
    logic clr_w;
    logic plain_w;

    always_comb begin
        wr_xp = i_wr && (i_addr == smac_pkg::ADDR_OPERAND_X_PLAIN);
        wr_yp = i_wr && (i_addr == smac_pkg::ADDR_OPERAND_Y_PLAIN);
        wr_xa = i_wr && (i_addr == smac_pkg::ADDR_OPERAND_X_ACCUM);
        wr_ya = i_wr && (i_addr == smac_pkg::ADDR_OPERAND_Y_ACCUM);
        mac_w = wr_xa || wr_ya;
        plain_w = wr_xp || wr_yp;
        clr_w = i_wr && ((i_addr == smac_pkg::ADDR_ACCUM_CLEAR_A) ||
                         (i_addr == smac_pkg::ADDR_ACCUM_CLEAR_B));
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared operands and product

    logic [7:0] x_r;
    logic [7:0] x_nxt;
    logic [7:0] y_r;
    logic [7:0] y_nxt;
    logic [15:0] prod_r;
    logic [15:0] prod_nxt;
    logic [15:0] prod_w;

    always_comb begin
        x_nxt = (wr_xp || wr_xa) ? i_wdata : x_r;
        y_nxt = (wr_yp || wr_ya) ? i_wdata : y_r;
        // Signed 8x8 product of the operands as they stand after the write
        prod_w = 16'($signed(x_nxt)) * 16'($signed(y_nxt));
        // Product registered at the write edge, readable next cycle
        prod_nxt = prod_w;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            x_r <= smac_pkg::RST_BYTE;
            y_r <= smac_pkg::RST_BYTE;
            prod_r <= smac_pkg::RST_PROD;
        end else begin
            x_r <= x_nxt;
            y_r <= y_nxt;
            prod_r <= prod_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator, low half at the write, upper half one cycle later

    logic [15:0] acc_lo_r;
    logic [15:0] acc_lo_nxt;
    logic [15:0] acc_hi_r;
    logic [15:0] acc_hi_nxt;
    logic [15:0] ext_r;
    logic [15:0] ext_nxt;
    logic carry_r;
    logic carry_nxt;

    smac_slice_if lo_if ();
    smac_slice_if hi_if ();

    smac_add16 u_lo (
        .s(lo_if.slice)
    );

    smac_add16 u_hi (
        .s(hi_if.slice)
    );

    assign lo_if.a = acc_lo_r;
    assign lo_if.b = prod_w;
    assign lo_if.cin = smac_pkg::RST_BIT;
    assign hi_if.a = acc_hi_r;
    assign hi_if.b = ext_r;
    assign hi_if.cin = carry_r;

    always_comb begin
        acc_lo_nxt = acc_lo_r;
        acc_hi_nxt = hi_if.sum;
        ext_nxt = smac_pkg::RST_HALF;
        carry_nxt = smac_pkg::RST_BIT;
        if (clr_w) begin
            // Clear wins over a same-cycle accumulate and kills pending half
            acc_lo_nxt = smac_pkg::RST_HALF;
            acc_hi_nxt = smac_pkg::RST_HALF;
        end else if (mac_w) begin
            // Low half now, carry and sign extension staged
            acc_lo_nxt = lo_if.sum;
            carry_nxt = lo_if.cout;
            ext_nxt = prod_w[15] ? smac_pkg::ONES_HALF : smac_pkg::RST_HALF;
            // Back-to-back accumulates lose nothing, a staged half is added the next cycle
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            acc_lo_r <= smac_pkg::RST_HALF;
            acc_hi_r <= smac_pkg::RST_HALF;
            ext_r <= smac_pkg::RST_HALF;
            carry_r <= smac_pkg::RST_BIT;
        end else begin
            acc_lo_r <= acc_lo_nxt;
            acc_hi_r <= acc_hi_nxt;
            ext_r <= ext_nxt;
            carry_r <= carry_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port

    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;

    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = i_rd;
        if (i_rd) begin
            // Operand and clear registers are write-only and read zero
            unique case (i_addr)
                smac_pkg::ADDR_PRODUCT_HIGH: begin
                    rdata_nxt = prod_r[15:8];
                end
                smac_pkg::ADDR_PRODUCT_LOW: begin
                    rdata_nxt = prod_r[7:0];
                end
                smac_pkg::ADDR_ACCUM_BYTE3: begin
                    rdata_nxt = acc_hi_r[15:8];
                end
                smac_pkg::ADDR_ACCUM_BYTE2: begin
                    rdata_nxt = acc_hi_r[7:0];
                end
                smac_pkg::ADDR_ACCUM_BYTE1: begin
                    rdata_nxt = acc_lo_r[15:8];
                end
                smac_pkg::ADDR_ACCUM_BYTE0: begin
                    rdata_nxt = acc_lo_r[7:0];
                end
                default: begin
                    rdata_nxt = smac_pkg::RST_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_r <= smac_pkg::RST_BYTE;
            rvalid_r <= smac_pkg::RST_BIT;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_rvalid = rvalid_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic [31:0] acc_full;
    assign acc_full = {acc_hi_r, acc_lo_r};

    AST_PLAIN_PRODUCT: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        plain_w |=> prod_r == 16'($signed(x_r)) * 16'($signed(y_r)))
    else $error("product does not match operands");

    AST_PLAIN_NO_ACC: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (plain_w && !clr_w) |=> $stable(acc_lo_r))
    else $error("plain multiply changed accumulator");

    AST_X_SHARED: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (wr_xp || wr_xa) |=> x_r == $past(i_wdata))
    else $error("x operand not loaded");

    AST_Y_SHARED: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (wr_yp || wr_ya) |=> y_r == $past(i_wdata))
    else $error("y operand not loaded");

    AST_CLEAR: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        clr_w |=> (acc_lo_r == 16'h0000) && (acc_hi_r == 16'h0000))
    else $error("accumulator not cleared");

    AST_MAC_LOW_NOW: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (mac_w && !clr_w)
        |=> acc_lo_r == 16'($past(acc_lo_r) + $past(prod_w)))
    else $error("low accumulator half not updated");

    AST_MAC_FULL: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (mac_w && !clr_w && !$past(mac_w)) ##1 (!clr_w && !mac_w)
        |=> acc_full == 32'($past(acc_full, 2) +
            {{16{$past(prod_w[15], 2)}}, $past(prod_w, 2)}))
    else $error("accumulate sum wrong after settle");

    AST_RESET_ZERO: assert property (
        @(posedge i_mclk)
        $past(i_rst) |-> (acc_full == 32'h00000000) &&
            (prod_r == 16'h0000) && (x_r == 8'h00) && (y_r == 8'h00))
    else $error("state not zero after reset");

    AST_READ_PRODUCT: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (i_rd && i_addr == smac_pkg::ADDR_PRODUCT_HIGH)
        |=> o_rvalid && o_rdata == $past(prod_r[15:8]))
    else $error("product high read wrong");

    AST_READ_PRODUCT_LOW: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (i_rd && i_addr == smac_pkg::ADDR_PRODUCT_LOW)
        |=> o_rvalid && o_rdata == $past(prod_r[7:0]))
    else $error("product low read wrong");

    AST_READ_ACC_BYTE0: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (i_rd && i_addr == smac_pkg::ADDR_ACCUM_BYTE0)
        |=> o_rvalid && o_rdata == $past(acc_lo_r[7:0]))
    else $error("accumulator byte 0 read wrong");

    AST_READ_ACC_BYTE3: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (i_rd && i_addr == smac_pkg::ADDR_ACCUM_BYTE3)
        |=> o_rvalid && o_rdata == $past(acc_hi_r[15:8]))
    else $error("accumulator byte 3 read wrong");

    AST_READ_WO_ZERO: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (i_rd && (i_addr == smac_pkg::ADDR_OPERAND_X_PLAIN ||
                  i_addr == smac_pkg::ADDR_ACCUM_CLEAR_A))
        |=> o_rdata == smac_pkg::RST_BYTE)
    else $error("write-only register read not zero");

    AST_RVALID_PULSE: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        !$past(i_rst) |-> o_rvalid == $past(i_rd))
    else $error("read valid not one cycle after read");

    AST_READ_STANDS: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        !i_rd |=> $stable(o_rdata))
    else $error("read data changed without a read");

    AST_LOW_HOLD: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (!mac_w && !clr_w) |=> $stable(acc_lo_r))
    else $error("low accumulator half moved without cause");

    AST_HI_HOLD: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (!clr_w && !$past(mac_w)) |=> $stable(acc_hi_r))
    else $error("upper accumulator half moved without cause");

    AST_PROD_HOLD: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        !(wr_xp || wr_yp || wr_xa || wr_ya) |=> $stable(prod_r))
    else $error("product changed without operand write");

endmodule
`default_nettype wire

// >>> verif/smac_cpu.sv
// CPU-side bus model that drives the unit's register port
`default_nettype none
module smac_cpu (
    // Clock
    input wire logic i_mclk,
    // Bus towards the unit
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    // Read answer
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Each call enters just after a falling edge; wr and rd span one cycle, idle spans n cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        o_addr = a;
        o_wdata = d;
        o_rd = 1'b0;
        o_wr = 1'b1;
        @(negedge i_mclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        o_addr = a;
        o_wr = 1'b0;
        o_rd = 1'b1;
        @(negedge i_mclk);
        d = i_rdata;
        v = i_rvalid;
    endtask

    // Released address and data lines show the inverse of their last value; wr and rd go low
    // Idle cycle also spaces accumulate writes and upper reads
    task automatic idle(input int n);
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
        repeat (n) @(negedge i_mclk);
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the multiply-accumulate unit
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk;
    logic i_rst;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, rvalid;
    logic [31:0] acc_exp;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    smac_unit dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_rvalid(rvalid));
    smac_cpu cpu (.i_mclk(i_mclk), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd), .i_rdata(rdata), .i_rvalid(rvalid));

    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] sp(input logic [7:0] x, input logic [7:0] y);
        logic [15:0] p;
        p = $signed(x) * $signed(y);
        return {{16{p[15]}}, p};
    endfunction

    task automatic rdb(input logic [7:0] a, output logic [7:0] d);
        logic v;
        cpu.rd(a, d, v);
        chk({31'h0, v}, 32'h1);
    endtask

    // Byte 0 read the very next cycle, upper bytes only after the two low-byte reads
    task automatic chk_acc();
        logic [7:0] b0, b1, b2, b3;
        rdb(smac_pkg::ADDR_ACCUM_BYTE0, b0);
        rdb(smac_pkg::ADDR_ACCUM_BYTE1, b1);
        rdb(smac_pkg::ADDR_ACCUM_BYTE2, b2);
        rdb(smac_pkg::ADDR_ACCUM_BYTE3, b3);
        cpu.idle(1);
        chk({b3, b2, b1, b0}, acc_exp);
    endtask

    task automatic chk_prod(input logic [31:0] exp);
        logic [7:0] lo, hi;
        rdb(smac_pkg::ADDR_PRODUCT_LOW, lo);
        rdb(smac_pkg::ADDR_PRODUCT_HIGH, hi);
        cpu.idle(1);
        chk({16'h0, hi, lo}, {16'h0, exp[15:0]});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] d;
        for (int a = 0; a < 13; a++) begin
            rdb(a[7:0], d);
            chk({24'h0, d}, 32'h0);
        end
        cpu.idle(1);
        $display("test reset done");
    endtask

    task automatic t_mul();
        logic [4:0][7:0] xs = {8'h80, 8'h80, 8'hff, 8'h7f, 8'h05};
        logic [4:0][7:0] ys = {8'h80, 8'h7f, 8'h01, 8'h7f, 8'hfd};
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            cpu.wr(smac_pkg::ADDR_OPERAND_X_PLAIN, xs[i]);
            cpu.wr(smac_pkg::ADDR_OPERAND_Y_PLAIN, ys[i]);
            chk_prod(sp(xs[i], ys[i]));
        end
        rdb(smac_pkg::ADDR_OPERAND_X_PLAIN, d);
        chk({24'h0, d}, 32'h0);
        acc_exp = 32'h0;
        chk_acc();
        $display("test multiply done");
    endtask

    task automatic t_mac();
        cpu.wr(smac_pkg::ADDR_ACCUM_CLEAR_A, 8'h5a);
        cpu.wr(smac_pkg::ADDR_OPERAND_X_PLAIN, 8'hff);
        cpu.wr(smac_pkg::ADDR_OPERAND_Y_ACCUM, 8'h01);
        acc_exp = sp(8'hff, 8'h01);
        chk_acc();
        cpu.wr(smac_pkg::ADDR_OPERAND_X_ACCUM, 8'h01);
        acc_exp = acc_exp + sp(8'h01, 8'h01);
        chk_acc();
        cpu.wr(smac_pkg::ADDR_OPERAND_Y_PLAIN, 8'h80);
        chk_prod(sp(8'h01, 8'h80));
        cpu.wr(smac_pkg::ADDR_OPERAND_X_ACCUM, 8'h80);
        cpu.idle(1);
        cpu.wr(smac_pkg::ADDR_OPERAND_Y_ACCUM, 8'h80);
        acc_exp = acc_exp + sp(8'h80, 8'h80) + sp(8'h80, 8'h80);
        chk_acc();
        chk_prod(sp(8'h80, 8'h80));
        cpu.wr(smac_pkg::ADDR_ACCUM_CLEAR_B, 8'h00);
        acc_exp = 32'h0;
        chk_acc();
        $display("test accumulate done");
    endtask

    // Reset in mid-run with non-zero state, then everything reads zero
    task automatic t_midrst();
        cpu.wr(smac_pkg::ADDR_OPERAND_X_PLAIN, 8'h7f);
        cpu.wr(smac_pkg::ADDR_OPERAND_Y_ACCUM, 8'h7f);
        cpu.idle(1);
        i_rst = 1'b1;
        cpu.idle(2);
        i_rst = 1'b0;
        t_reset();
        $display("test mid-run reset done");
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        i_rst = 1'b1;
        repeat (20) @(negedge i_mclk);
        i_rst = 1'b0;
        t_reset();
        t_mul();
        t_mac();
        t_midrst();
        final_report();
    end
endmodule
`default_nettype wire
